/* File: apd_cfg.svh */
/*
 * Constants for the automatic power-down controller: control bit positions,
 * reset values and inactivity count.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef APD_CFG_SVH
`define APD_CFG_SVH

// ----------------------------------------------------------------------------
// control bit positions and reset values
// ----------------------------------------------------------------------------
`define APD_PM0_ENABLE_BIT   1
`define APD_PM0_SLOW_BIT     3
`define APD_PM0_ARRAYCLK_BIT 4
`define APD_PM0_MCELLCLK_BIT 5
`define APD_PM0_RESET        8'h00

// ----------------------------------------------------------------------------
// inactivity counter and external chip-select count
// ----------------------------------------------------------------------------
`define APD_CNT_W            4
`define APD_IDLE_PERIODS     4'hF
`define APD_NUM_ECS          3

`endif

/* File: apd_pkg.sv */
/*
 * Types for the automatic power-down controller.
 * Assumes apd_cfg.svh is reachable on the include path.
 */
`include "apd_cfg.svh"
package apd_pkg;
    typedef enum logic [1:0] {
        APD_RUN,
        APD_COUNT,
        APD_DOWN
    } apd_state_e;
    typedef logic [`APD_CNT_W-1:0] apd_cnt_t;
endpackage : apd_pkg

/* File: apd_ecs_pin.sv */
/*
 * One external chip-select pin: a product-term result with configurable
 * polarity and an output enable from its own term or the direction bit.
 * Assumes inputs come from logic on the same clock.
 */
module apd_ecs_pin (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_term,
    input  wire logic i_active_low,
    input  wire logic i_oe_term,
    input  wire logic i_dir_out,
    output logic      o_pin,
    output logic      o_pin_oe
);
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pin    <= 1'b0;
            o_pin_oe <= 1'b0;
        end else begin
            o_pin    <= i_term ^ i_active_low;
            o_pin_oe <= i_oe_term | i_dir_out;
        end
    end
endmodule // apd_ecs_pin

/* File: apd_controller.sv */
/*
 * Automatic power-down controller: strobe watch, inactivity counter on the
 * dedicated clock, bus gating and chip-select pins of port D.
 * Assumes strobe, clock input, chip select and reset come from pins and are
 * synchronised here; sampling at 100 MHz needs the pin clock well below that.
 */
// Functional notes
// - idle strobe starts four-bit counter on clock input
// - fifteen idle periods raise flag, enter power-down
// - enable bit is needed; alone it does not enter power-down
// - strobe pulses end power-down
// - chip select low or reset high wakes
// - power-down gates bus, deselects memories
// - blocking bits gate array inputs, not counter
// - memories standby; arrays and ports keep running
// - port pins follow as normal; bus pins tri-state
// - chip select high disables memories and io control
// - fast mode default on, set bit disables
// - three chip selects, configurable polarity
// - chip-select driver enabled by term or direction
// - clock input drives macrocells and counter
// - control bit 1 enables power-down unit
// - control bit 3 turns fast mode off
`include "apd_cfg.svh"
module apd_controller (
    input  wire logic                    I_REF_CLK,
    input  wire logic                    I_RST,
    input  wire logic [7:0]              I_PM_CTRL,
    input  wire logic                    I_BLOCK_CTRL_SIGS,
    input  wire logic                    I_ADDR_LATCH_STROBE,
    input  wire logic                    I_DEDICATED_CLOCK_INPUT,
    input  wire logic                    I_CHIP_SELECT_N,
    input  wire logic                    I_DEVICE_RESET,
    input  wire logic [7:0]              I_MCU_ADDR,
    input  wire logic [7:0]              I_MCU_DATA,
    input  wire logic [3:0]              I_MCU_CTRL,
    input  wire logic [`APD_NUM_ECS-1:0] I_ECS_TERM,
    input  wire logic [`APD_NUM_ECS-1:0] I_ECS_ACTIVE_LOW,
    input  wire logic [`APD_NUM_ECS-1:0] I_ECS_OE_TERM,
    input  wire logic [`APD_NUM_ECS-1:0] I_ECS_DIR_OUT,
    input  wire logic [7:0]              I_PORT_LEVEL,
    input  wire logic [7:0]              I_PORT_OE,
    input  wire logic [7:0]              I_PORT_IS_BUS,
    output logic                         O_POWERDOWN_FLAG,
    output logic                         O_MEM_SELECT_EN,
    output logic                         O_IO_CTRL_EN,
    output logic                         O_MEM_STANDBY,
    output logic                         O_FAST_MODE,
    output logic [7:0]                   O_MEM_ADDR,
    output logic [7:0]                   O_MEM_DATA,
    output logic [7:0]                   O_ARRAY_ADDR,
    output logic [3:0]                   O_ARRAY_CTRL,
    output logic                         O_ARRAY_CLK,
    output logic                         O_MCELL_CLK,
    output logic [7:0]                   O_PORT_LEVEL,
    output logic [7:0]                   O_PORT_OE,
    output logic [`APD_NUM_ECS-1:0]      O_ECS,
    output logic [`APD_NUM_ECS-1:0]      O_ECS_OE
);
    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic       strobe_d_reg;
    logic       dedicated_clock_input_d_reg;
    logic       strobe_s;
    logic       dedicated_clock_input_s;
    logic       csn_s;
    logic       devrst_s;

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            sync1_reg <= 4'h4;
            sync2_reg <= 4'h4;
        end else begin
            sync1_reg <= {I_DEVICE_RESET, I_CHIP_SELECT_N,
                          I_DEDICATED_CLOCK_INPUT, I_ADDR_LATCH_STROBE};
            sync2_reg <= sync1_reg;
        end
    end
    assign strobe_s = sync2_reg[0];
    assign dedicated_clock_input_s  = sync2_reg[1];
    assign csn_s    = sync2_reg[2];
    assign devrst_s = sync2_reg[3];

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            strobe_d_reg <= 1'b0;
            dedicated_clock_input_d_reg  <= 1'b0;
        end else begin
            strobe_d_reg <= strobe_s;
            dedicated_clock_input_d_reg  <= dedicated_clock_input_s;
        end
    end

    logic strobe_edge;
    logic dedicated_clock_input_rise;
    logic apd_en;
    logic wake;
    assign strobe_edge = strobe_s ^ strobe_d_reg;
    assign dedicated_clock_input_rise  = dedicated_clock_input_s & ~dedicated_clock_input_d_reg;
    assign apd_en      = I_PM_CTRL[`APD_PM0_ENABLE_BIT];
    assign wake        = ~csn_s | devrst_s;

    // ------------------------------------------------------------------------
    // inactivity counter and power-down state
    // ------------------------------------------------------------------------
    apd_pkg::apd_state_e state_reg;
    apd_pkg::apd_cnt_t   cnt_reg;

    // counter sees the unblocked clock input, whatever the array blocking says
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            state_reg <= apd_pkg::APD_RUN;
            cnt_reg   <= '0;
        end else begin
            case (state_reg)
                apd_pkg::APD_RUN: begin
                    cnt_reg <= '0;
                    if (apd_en && !strobe_edge && !wake) begin
                        state_reg <= apd_pkg::APD_COUNT;
                    end
                end
                apd_pkg::APD_COUNT: begin
                    if (!apd_en || wake) begin
                        state_reg <= apd_pkg::APD_RUN;
                        cnt_reg   <= '0;
                    end else if (strobe_edge) begin
                        cnt_reg <= '0;
                    end else if (dedicated_clock_input_rise) begin
                        if (cnt_reg == `APD_IDLE_PERIODS - 4'h1) begin
                            state_reg <= apd_pkg::APD_DOWN;
                        end
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                apd_pkg::APD_DOWN: begin
                    if (strobe_edge || wake || !apd_en) begin
                        state_reg <= apd_pkg::APD_RUN;
                        cnt_reg   <= '0;
                    end
                end
                default: begin
                    state_reg <= apd_pkg::APD_RUN;
                    cnt_reg   <= '0;
                end
            endcase
        end
    end

    logic powerdown_flag;
    assign powerdown_flag = (state_reg == apd_pkg::APD_DOWN);

    // ------------------------------------------------------------------------
    // gating of memories and logic arrays
    // ------------------------------------------------------------------------
    logic blk_array_clk;
    logic blk_mcell_clk;
    assign blk_array_clk = I_PM_CTRL[`APD_PM0_ARRAYCLK_BIT];
    assign blk_mcell_clk = I_PM_CTRL[`APD_PM0_MCELLCLK_BIT];

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            O_POWERDOWN_FLAG <= 1'b0;
            O_MEM_SELECT_EN  <= 1'b0;
            O_IO_CTRL_EN     <= 1'b0;
            O_MEM_STANDBY    <= 1'b1;
            O_FAST_MODE      <= 1'b1;
            O_MEM_ADDR       <= 8'h00;
            O_MEM_DATA       <= 8'h00;
        end else begin
            O_POWERDOWN_FLAG <= powerdown_flag;
            O_MEM_SELECT_EN  <= ~powerdown_flag & ~csn_s;
            O_IO_CTRL_EN     <= ~powerdown_flag & ~csn_s;
            O_MEM_STANDBY    <= powerdown_flag | csn_s;
            O_FAST_MODE      <= ~I_PM_CTRL[`APD_PM0_SLOW_BIT];
            if (!powerdown_flag) begin
                O_MEM_ADDR <= I_MCU_ADDR;
                O_MEM_DATA <= I_MCU_DATA;
            end
        end
    end

    // arrays keep running in power-down; only their bus inputs freeze
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            O_ARRAY_ADDR <= 8'h00;
            O_ARRAY_CTRL <= 4'h0;
            O_ARRAY_CLK  <= 1'b0;
            O_MCELL_CLK  <= 1'b0;
        end else begin
            if (!powerdown_flag) begin
                O_ARRAY_ADDR <= I_MCU_ADDR;
            end
            // blocking bits are sampled live so run-time rewrites act at once
            if (!I_BLOCK_CTRL_SIGS && !powerdown_flag) begin
                O_ARRAY_CTRL <= I_MCU_CTRL;
            end
            O_ARRAY_CLK <= dedicated_clock_input_s & ~blk_array_clk;
            O_MCELL_CLK <= dedicated_clock_input_s & ~blk_mcell_clk;
        end
    end

    // ------------------------------------------------------------------------
    // port pin behaviour in power-down
    // ------------------------------------------------------------------------
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            O_PORT_LEVEL <= 8'h00;
            O_PORT_OE    <= 8'h00;
        end else begin
            // io and logic pins follow as normal; bus pins float in power-down
            O_PORT_LEVEL <= I_PORT_LEVEL;
            O_PORT_OE    <= powerdown_flag ? (I_PORT_OE & ~I_PORT_IS_BUS) : I_PORT_OE;
        end
    end

    // ------------------------------------------------------------------------
    // external chip selects
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `APD_NUM_ECS; gi = gi + 1) begin : g_ecs
            apd_ecs_pin u_ecs (
                .i_clk        (I_REF_CLK),
                .i_rst        (I_RST),
                .i_term       (I_ECS_TERM[gi]),
                .i_active_low (I_ECS_ACTIVE_LOW[gi]),
                .i_oe_term    (I_ECS_OE_TERM[gi]),
                .i_dir_out    (I_ECS_DIR_OUT[gi]),
                .o_pin        (O_ECS[gi]),
                .o_pin_oe     (O_ECS_OE[gi])
            );
        end
    endgenerate
endmodule // apd_controller

/* File: apd_controller_sva.sv */
/* Checker for the power-down controller, bound to its top module.
   Assumes the pin inputs change well apart from one another. */
`include "apd_cfg.svh"
module apd_controller_sva (
    input wire logic       I_REF_CLK,
    input wire logic       I_RST,
    input wire logic [7:0] I_PM_CTRL,
    input wire logic       I_ADDR_LATCH_STROBE,
    input wire logic       I_DEDICATED_CLOCK_INPUT,
    input wire logic       I_CHIP_SELECT_N,
    input wire logic       I_DEVICE_RESET,
    input wire logic       O_POWERDOWN_FLAG,
    input wire logic       O_MEM_SELECT_EN,
    input wire logic       O_MEM_STANDBY,
    input wire logic       O_FAST_MODE,
    input wire logic [7:0] O_MEM_ADDR,
    input wire logic       O_ARRAY_CLK
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);
    // ----------
    // idle run: clock rises seen since the last strobe edge or wake cause
    // ----------
    logic [4:0] rise_cnt_reg;
    logic       dclk_d_reg;
    logic       stb_d_reg;
    always_ff @(posedge I_REF_CLK) begin
        dclk_d_reg <= I_DEDICATED_CLOCK_INPUT;
        stb_d_reg  <= I_ADDR_LATCH_STROBE;
    end
    // saturates so that long idle runs cannot wrap back below fifteen
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST || stb_d_reg != I_ADDR_LATCH_STROBE || !I_PM_CTRL[1] || !I_CHIP_SELECT_N
            || I_DEVICE_RESET) begin
            rise_cnt_reg <= 5'h00;
        end else if (I_DEDICATED_CLOCK_INPUT && !dclk_d_reg && rise_cnt_reg != 5'h1F) begin
            rise_cnt_reg <= rise_cnt_reg + 5'h01;
        end
    end
    chk_fast_follows: assert property (!$past(I_RST) |-> O_FAST_MODE == !$past(I_PM_CTRL[3]))
        else $error("fast mode not the inverse of the control bit");
    chk_down_standby: assert property (O_POWERDOWN_FLAG |-> O_MEM_STANDBY && !O_MEM_SELECT_EN)
        else $error("memories not in standby during power-down");
    chk_cs_deselect: assert property (I_CHIP_SELECT_N [*5] |-> !O_MEM_SELECT_EN)
        else $error("memories selected with chip select high");
    chk_cs_wakes: assert property (!I_CHIP_SELECT_N [*5] |-> !O_POWERDOWN_FLAG)
        else $error("power-down held with chip select low");
    chk_reset_wakes: assert property (I_DEVICE_RESET [*5] |-> !O_POWERDOWN_FLAG)
        else $error("power-down held with device reset high");
    chk_enable_off: assert property (!I_PM_CTRL[1] [*5] |-> !O_POWERDOWN_FLAG)
        else $error("power-down with the unit disabled");
    chk_addr_frozen: assert property (
        O_POWERDOWN_FLAG && $past(O_POWERDOWN_FLAG) |-> $stable(O_MEM_ADDR))
        else $error("memory address moved during power-down");
    chk_idle_run: assert property ($rose(O_POWERDOWN_FLAG) |-> rise_cnt_reg >= 5'h0F)
        else $error("power-down before fifteen idle clock periods");
    chk_enter_on15: assert property (
        rise_cnt_reg == 5'h0F && $past(rise_cnt_reg) == 5'h0E |-> ##[1:8] O_POWERDOWN_FLAG)
        else $error("no power-down after fifteen idle clock periods");
    chk_strobe_wakes: assert property (
        O_POWERDOWN_FLAG && $changed(I_ADDR_LATCH_STROBE) |-> ##[1:6] !O_POWERDOWN_FLAG)
        else $error("strobe activity did not end power-down");
    chk_aclk_block: assert property (I_PM_CTRL[4] [*4] |-> !O_ARRAY_CLK)
        else $error("array clock passed while blocked");
endmodule // apd_controller_sva
bind apd_controller apd_controller_sva apd_controller_sva_i (.I_REF_CLK(I_REF_CLK),
    .I_RST(I_RST), .I_PM_CTRL(I_PM_CTRL), .I_ADDR_LATCH_STROBE(I_ADDR_LATCH_STROBE),
    .I_DEDICATED_CLOCK_INPUT(I_DEDICATED_CLOCK_INPUT), .I_CHIP_SELECT_N(I_CHIP_SELECT_N),
    .I_DEVICE_RESET(I_DEVICE_RESET), .O_POWERDOWN_FLAG(O_POWERDOWN_FLAG),
    .O_MEM_SELECT_EN(O_MEM_SELECT_EN), .O_MEM_STANDBY(O_MEM_STANDBY),
    .O_FAST_MODE(O_FAST_MODE), .O_MEM_ADDR(O_MEM_ADDR), .O_ARRAY_CLK(O_ARRAY_CLK));

/* File: apd_mcu_model.sv */
/* Sleepy microcontroller: address strobe activity and an oscillator on the clock pin.
   Assumes the bench switches either source on and off between falling edges. */
module apd_mcu_model (
    input  wire logic i_clk,
    input  wire logic i_strobe_on,
    input  wire logic i_clock_on,
    output logic      o_strobe = 1'b0,
    output logic      o_dclk = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_reg = 2'h0;
    always_ff @(negedge i_clk) begin
        if (i_strobe_on) begin
            o_strobe <= !o_strobe;
        end
    end
    // clock stands low when off; restarting phase keeps rise times predictable
    always_ff @(negedge i_clk) begin
        if (!i_clock_on) begin
            div_reg <= 2'h0;
            o_dclk  <= 1'b0;
        end else begin
            div_reg <= div_reg + 2'h1;
            if (div_reg == 2'h3) begin
                o_dclk <= !o_dclk;
            end
        end
    end
endmodule // apd_mcu_model

/* File: tb_top.sv */
/* Self-checking bench for the power-down controller.
   Assumes the checker is bound at elaboration and the include path holds the config. */
`include "apd_cfg.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
    $display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, rst = 1'b1, csn = 1'b1, drst = 1'b0, stb_on = 1'b0, clk_on = 1'b0;
    logic       stb, dclk, flag, msel, ioen, stby, fast;
    logic [7:0] pm = 8'h00, addr = 8'h00, data = 8'h00, plev_in = 8'h00;
    logic [7:0] maddr, mdata, aaddr, plev, port_oe;
    logic [3:0] ctrl = 4'h0, actrl;
    logic       blk = 1'b0, aclk, mclk, aseen, mseen;
    logic [2:0] et = 3'h0, eal = 3'h0, eoe = 3'h0, edir = 3'h0, ecs, ecs_oe;
    int         err_count = 0, samples_checked = 0;
    apd_mcu_model apd_mcu_model_i (.i_clk(clk), .i_strobe_on(stb_on), .i_clock_on(clk_on),
        .o_strobe(stb), .o_dclk(dclk));
    apd_controller apd_controller_i (.I_REF_CLK(clk), .I_RST(rst), .I_PM_CTRL(pm),
        .I_BLOCK_CTRL_SIGS(blk), .I_ADDR_LATCH_STROBE(stb), .I_DEDICATED_CLOCK_INPUT(dclk),
        .I_CHIP_SELECT_N(csn), .I_DEVICE_RESET(drst), .I_MCU_ADDR(addr), .I_MCU_DATA(data),
        .I_MCU_CTRL(ctrl), .I_ECS_TERM(et), .I_ECS_ACTIVE_LOW(eal), .I_ECS_OE_TERM(eoe),
        .I_ECS_DIR_OUT(edir), .I_PORT_LEVEL(plev_in), .I_PORT_OE(8'hFF), .I_PORT_IS_BUS(8'hF0),
        .O_POWERDOWN_FLAG(flag), .O_MEM_SELECT_EN(msel), .O_IO_CTRL_EN(ioen),
        .O_MEM_STANDBY(stby), .O_FAST_MODE(fast), .O_MEM_ADDR(maddr), .O_MEM_DATA(mdata),
        .O_ARRAY_ADDR(aaddr), .O_ARRAY_CTRL(actrl), .O_ARRAY_CLK(aclk), .O_MCELL_CLK(mclk),
        .O_PORT_LEVEL(plev), .O_PORT_OE(port_oe), .O_ECS(ecs), .O_ECS_OE(ecs_oe));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // notes whether either array clock output was ever seen high
    task automatic watch(input int n);
        repeat (n) begin
            @(negedge clk);
            aseen |= aclk;
            mseen |= mclk;
        end
    endtask
    // a strobe burst mid-count restarts the run; fourteen rises after it are not enough
    task automatic enter_pd();
        int k;
        aseen = 1'b0;
        mseen = 1'b0;
        stb_on <= 1'b1;
        cyc(10);
        stb_on <= 1'b0;
        cyc(10);
        clk_on <= 1'b1;
        watch(60);
        stb_on <= 1'b1;
        cyc(2);
        stb_on <= 1'b0;
        watch(114);
        `CHK(flag, 1'b0)
        k = 0;
        while (flag !== 1'b1 && k < 20) begin
            cyc(1);
            k++;
        end
        clk_on <= 1'b0;
        `CHK(flag, 1'b1)
        `CHK({aseen, mseen}, 2'h1)
    endtask
    // run-time blocking of control signals; bus and port levels pass when awake
    task automatic t_block();
        ctrl    <= 4'hA;
        data    <= 8'h5A;
        addr    <= 8'hC3;
        plev_in <= 8'h96;
        cyc(2);
        `CHK(actrl, 4'hA)
        `CHK({mdata, aaddr}, 16'h5AC3)
        `CHK(plev, 8'h96)
        blk  <= 1'b1;
        ctrl <= 4'h5;
        cyc(2);
        `CHK(actrl, 4'hA)
        blk <= 1'b0;
        cyc(2);
        `CHK(actrl, 4'h5)
    endtask
    task automatic t_fast();
        pm <= 8'h08;
        cyc(2);
        `CHK(fast, 1'b0)
        pm <= 8'h00;
        cyc(2);
        `CHK(fast, 1'b1)
    endtask
    task automatic t_cs();
        csn <= 1'b0;
        cyc(6);
        `CHK({msel, ioen}, 2'h3)
        csn <= 1'b1;
        cyc(6);
        `CHK({msel, ioen}, 2'h0)
    endtask
    task automatic t_ecs();
        eal  <= 3'h5;
        edir <= 3'h2;
        for (int i = 0; i < 8; i++) begin
            et  <= i[2:0];
            eoe <= i[2:0];
            cyc(3);
            `CHK(ecs, i[2:0] ^ 3'h5)
            `CHK(ecs_oe, i[2:0] | 3'h2)
        end
    endtask
    // one entry per wake cause: strobe, chip select, device reset, enable clear
    task automatic t_pd();
        logic [7:0] held;
        pm <= 8'h12;
        for (int w = 0; w < 4; w++) begin
            data <= addr;
            enter_pd();
            held = addr;
            addr <= ~held;
            data <= ~held;
            mseen = 1'b0;
            clk_on <= 1'b1;
            watch(12);
            clk_on <= 1'b0;
            `CHK({maddr, aaddr, mdata}, {3{held}})
            `CHK(stby, 1'b1)
            `CHK({flag, aseen, mseen}, 3'h5)
            `CHK(port_oe, 8'h0F)
            case (w)
                0: stb_on <= 1'b1;
                1: csn <= 1'b0;
                2: drst <= 1'b1;
                default: pm <= 8'h00;
            endcase
            cyc(8);
            `CHK(flag, 1'b0)
            `CHK(maddr, ~held)
            stb_on <= 1'b0;
            csn    <= 1'b1;
            drst   <= 1'b0;
            pm     <= 8'h12;
            cyc(8);
        end
    endtask
    task automatic t_noen();
        pm     <= 8'h30;
        clk_on <= 1'b1;
        aseen = 1'b0;
        mseen = 1'b0;
        watch(170);
        `CHK(flag, 1'b0)
        `CHK({aseen, mseen}, 2'h0)
        clk_on <= 1'b0;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        cyc(20);
        `CHK({flag, stby, fast}, 3'h3)
        rst <= 1'b0;
        cyc(2);
        t_fast();
        t_cs();
        t_ecs();
        t_block();
        t_pd();
        t_noen();
        complete_run();
    end
    initial begin
        #100000;
        err_count++;
        complete_run();
    end
endmodule // tb_top
